// ==== rtl/lcc_cfg.svh ====
// Offsets, field positions, reset values and counts for the link capability
// and link control register bank. Included by the package and the register bank design file.
`ifndef LCC_CFG_SVH
`define LCC_CFG_SVH

`define LCC_OFS_LINK_CAP        8'hec
`define LCC_OFS_LINK_CTRL       8'hf0

`define LCC_CAP_SPEED_LSB       0
`define LCC_CAP_WIDTH_LSB       4
`define LCC_CAP_ASPM_LSB        10
`define LCC_CAP_L0S_LSB         12
`define LCC_CAP_L1_LSB          15
`define LCC_CAP_SDE_BIT         19
`define LCC_CAP_DLL_BIT         20
`define LCC_CAP_PORT_LSB        24

`define LCC_CTL_ASPM_LSB        0
`define LCC_CTL_RCB_BIT         3
`define LCC_CTL_DIS_BIT         4
`define LCC_CTL_RETRAIN_BIT     5
`define LCC_CTL_CCLK_BIT        6
`define LCC_CTL_XSYNC_BIT       7

`define LCC_STA_SPEED_LSB       16
`define LCC_STA_NWIDTH_LSB      20
`define LCC_STA_TRAIN_BIT       27
`define LCC_STA_DLACT_BIT       29

`define LCC_SPEED_2G5           4'h1
`define LCC_RST_WIDTH           6'h01
`define LCC_RST_ASPM_SUP        2'h1
`define LCC_RST_L0S_LAT         3'h3
`define LCC_RST_L1_LAT          3'h0
`define LCC_RST_ASPM_CTL        2'h0

`define LCC_XSYNC_FTS           13'h1000
`define LCC_XSYNC_TS1           13'h0400
`define LCC_NORM_FTS            13'h0080
`define LCC_NORM_TS1            13'h0010

`endif

// ==== rtl/lcc_pkg.sv ====
// Types shared by the link capability and link control register bank.
// Assumes lcc_cfg.svh is on the include path.
`include "lcc_cfg.svh"

package lcc_pkg;

    // Values that a strap, SMBus or EEPROM preload may place in the capability.
    typedef struct packed {
        logic [1:0] aspm_sup;
        logic [2:0] l0s_lat;
        logic [2:0] l1_lat;
        logic [7:0] port_num;
        logic [5:0] max_width;
    } lcc_preload_s;

    // Control settings driven toward the link training logic.
    typedef struct packed {
        logic        l0s_en;
        logic        l1_en;
        logic        rx_l0s_ok;
        logic        link_disable;
        logic        common_clk;
        logic        ext_sync;
        logic [12:0] fts_count;
        logic [12:0] ts1_count;
    } lcc_ctrl_s;

endpackage

// ==== rtl/lcc_train_track.sv ====
// Link-training status flag tracker.
// Assumes training start and done events are one-cycle pulses on clk_i.
module lcc_train_track (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    input  wire logic active_i,
    input  wire logic done_i,
    output logic      training_o
);

    // set and clear
    // A start or active level in the cycle of a done pulse keeps the flag set.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            training_o <= 1'b0;
        end else if (start_i || active_i) begin
            training_o <= 1'b1;
        end else if (done_i) begin
            training_o <= 1'b0;
        end
    end

endmodule

// ==== rtl/lcc_link_regs.sv ====
// Link capability and link control register bank for one port, on a classic
// Wishbone slave. Assumes a synchronous strap input and one-cycle pulses from
// the link training logic and from the SMBus/EEPROM preload path.
//
// Behaviour
// - Maximum link speed field always reads the 2.5 Gb/s code.
// - Maximum link width comes from the strap or an EEPROM preload.
// - ASPM support resets to L0s-only code; preload may override.
// - L0s exit latency resets to 256 ns code; preload may override.
// - L1 exit latency resets to under 1 us code; preload may override.
// - Surprise-down capability is zero upstream, set downstream only if supported.
// - Link-active reporting reads zero upstream, one on hot-plug downstream ports.
// - Port number resets to port index; preload may override.
// - ASPM control selects none, L0s, L1 or both; resets to zero.
// - Receiver stays able to enter L0s whatever the ASPM control.
// - Read completion boundary bit always reads zero.
// - Link disable is zero upstream; downstream it disables the link.
// - Retrain write starts retraining downstream; bit always reads zero.
// - Common clock bit records shared reference clock; resets to zero.
// - Extended sync sends 4096 FTS from L0s and 1024 TS1 from L1.
// - Training flag set during training and retraining, cleared on completion.
`include "lcc_cfg.svh"

module lcc_link_regs #(
    parameter int unsigned PORT_INDEX   = 0,
    parameter bit          SDE_SUPPORT  = 1'b0,
    parameter bit          HOTPLUG_CAP  = 1'b0
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic [5:0]           width_strap_i,
    input  wire logic                 preload_valid_i,
    input  wire lcc_pkg::lcc_preload_s preload_i,
    input  wire logic                 train_active_i,
    input  wire logic                 train_done_i,
    input  wire logic [5:0]           neg_width_i,
    input  wire logic                 dl_active_i,
    output lcc_pkg::lcc_ctrl_s        ctrl_o,
    output logic                      retrain_o
);

    // Port 0 faces the host; every other index is a downstream port.
    localparam bit IS_DOWN = (PORT_INDEX != 0);

    localparam bit SDE_BIT = IS_DOWN && SDE_SUPPORT;
    localparam bit DLL_BIT = IS_DOWN && HOTPLUG_CAP;
    localparam logic [7:0] PORT_RST = 8'(PORT_INDEX);

    logic [5:0] width_reg;
    logic       strap_taken_reg;
    logic [1:0] aspm_sup_reg;
    logic [2:0] l0s_lat_reg;
    logic [2:0] l1_lat_reg;
    logic [7:0] port_num_reg;
    logic [1:0] aspm_ctl_reg;
    logic       disable_reg;
    logic       cclk_reg;
    logic       xsync_reg;
    logic       training;
    logic [31:0] cap_word;
    logic [31:0] ctl_word;
    logic        bus_req;
    logic        wr_ctl;
    logic        retrain_req;
    logic [31:0] sta_word;
    logic [31:0] cap_mask;
    logic [31:0] ctl_mask;
    logic [31:0] rd_word;

    // Decodes an address to the word it reads; unmapped reads give zero.
    function automatic logic [31:0] read_mux(input logic [7:0] adr,
                                             input logic [31:0] cap,
                                             input logic [31:0] ctl);
        case (adr)
            `LCC_OFS_LINK_CAP:  read_mux = cap;
            `LCC_OFS_LINK_CTRL: read_mux = ctl;
            default:            read_mux = 32'h0000_0000;
        endcase
    endfunction

    // True where a capability field owns the bit; the rest is reserved.
    function automatic logic cap_owned(input int pos);
        cap_owned = 1'b0;
        if (pos < `LCC_CAP_L1_LSB + 3) begin
            cap_owned = 1'b1;
        end
        if (pos == `LCC_CAP_SDE_BIT || pos == `LCC_CAP_DLL_BIT) begin
            cap_owned = 1'b1;
        end
        if (pos >= `LCC_CAP_PORT_LSB) begin
            cap_owned = 1'b1;
        end
    endfunction

    // True where a control or status field owns the bit; the rest is reserved.
    function automatic logic ctl_owned(input int pos);
        ctl_owned = 1'b0;
        if (pos < `LCC_CTL_ASPM_LSB + 2 || pos == `LCC_CTL_DIS_BIT) begin
            ctl_owned = 1'b1;
        end
        if (pos == `LCC_CTL_CCLK_BIT || pos == `LCC_CTL_XSYNC_BIT) begin
            ctl_owned = 1'b1;
        end
        if (pos >= `LCC_STA_SPEED_LSB && pos < `LCC_STA_NWIDTH_LSB + 6) begin
            ctl_owned = 1'b1;
        end
        if (pos == `LCC_STA_TRAIN_BIT || pos == `LCC_STA_DLACT_BIT) begin
            ctl_owned = 1'b1;
        end
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // read-only ignored
    // Only byte 0 of the control word holds writable bits, so a write that
    // misses it, or lands on the capability word, changes nothing.
    assign wr_ctl  = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `LCC_OFS_LINK_CTRL);
    assign retrain_req = wr_ctl && IS_DOWN && wb_dat_i[`LCC_CTL_RETRAIN_BIT];

    // reserved mask
    // A bit that no field owns is forced to zero on the way out, so a slip in
    // the word packing below cannot leak into a reserved position.
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_rsvd_mask
            assign cap_mask[gi] = cap_owned(gi);
            assign ctl_mask[gi] = ctl_owned(gi);
        end
    endgenerate

    assign rd_word = read_mux(wb_adr_i, cap_word & cap_mask, ctl_word & ctl_mask);

    // strap capture
    // The strap is sampled in the first cycle after reset rather than in reset,
    // so a preload arriving later still wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            width_reg <= `LCC_RST_WIDTH;
        end else if (preload_valid_i) begin
            width_reg <= preload_i.max_width;
        end else if (!strap_taken_reg) begin
            width_reg <= width_strap_i;
        end
    end

    // The strap is a one-shot: a later preload owns the width until reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_taken_reg <= 1'b0;
        end else begin
            strap_taken_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aspm_sup_reg <= `LCC_RST_ASPM_SUP;
        end else if (preload_valid_i) begin
            aspm_sup_reg <= preload_i.aspm_sup;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            l0s_lat_reg <= `LCC_RST_L0S_LAT;
        end else if (preload_valid_i) begin
            l0s_lat_reg <= preload_i.l0s_lat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            l1_lat_reg <= `LCC_RST_L1_LAT;
        end else if (preload_valid_i) begin
            l1_lat_reg <= preload_i.l1_lat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_num_reg <= PORT_RST;
        end else if (preload_valid_i) begin
            port_num_reg <= preload_i.port_num;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aspm_ctl_reg <= `LCC_RST_ASPM_CTL;
        end else if (wr_ctl) begin
            aspm_ctl_reg <= wb_dat_i[`LCC_CTL_ASPM_LSB +: 2];
        end
    end

    // downstream disable
    // An upstream port keeps the bit at zero whatever is written.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disable_reg <= 1'b0;
        end else if (wr_ctl) begin
            disable_reg <= IS_DOWN && wb_dat_i[`LCC_CTL_DIS_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cclk_reg <= 1'b0;
        end else if (wr_ctl) begin
            cclk_reg <= wb_dat_i[`LCC_CTL_CCLK_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xsync_reg <= 1'b0;
        end else if (wr_ctl) begin
            xsync_reg <= wb_dat_i[`LCC_CTL_XSYNC_BIT];
        end
    end

    // training flag
    // The set-wins ordering of start against done is kept in one small module.
    lcc_train_track u_train (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .start_i    (retrain_req),
        .active_i   (train_active_i),
        .done_i     (train_done_i),
        .training_o (training)
    );

    always_comb begin
        cap_word = 32'h0000_0000;
        cap_word[`LCC_CAP_SPEED_LSB +: 4] = `LCC_SPEED_2G5;
        cap_word[`LCC_CAP_WIDTH_LSB +: 6] = width_reg;
        cap_word[`LCC_CAP_ASPM_LSB +: 2]  = aspm_sup_reg;
        cap_word[`LCC_CAP_L0S_LSB +: 3]   = l0s_lat_reg;
        cap_word[`LCC_CAP_L1_LSB +: 3]    = l1_lat_reg;
        cap_word[`LCC_CAP_SDE_BIT]        = SDE_BIT;
        cap_word[`LCC_CAP_DLL_BIT]        = DLL_BIT;
        cap_word[`LCC_CAP_PORT_LSB +: 8]  = port_num_reg;
    end

    // status half
    // The upper half carries the link status so software sees training progress.
    always_comb begin
        sta_word = 32'h0000_0000;
        sta_word[`LCC_STA_SPEED_LSB +: 4]  = `LCC_SPEED_2G5;
        sta_word[`LCC_STA_NWIDTH_LSB +: 6] = neg_width_i;
        sta_word[`LCC_STA_TRAIN_BIT]       = training;
        sta_word[`LCC_STA_DLACT_BIT]       = dl_active_i;
    end

    // retrain reads zero
    // Bits 3 and 5 are never placed here, so both always read back as zero.
    always_comb begin
        ctl_word = sta_word;
        ctl_word[`LCC_CTL_ASPM_LSB +: 2] = aspm_ctl_reg;
        ctl_word[`LCC_CTL_DIS_BIT]       = disable_reg;
        ctl_word[`LCC_CTL_CCLK_BIT]      = cclk_reg;
        ctl_word[`LCC_CTL_XSYNC_BIT]     = xsync_reg;
    end

    // Every access, mapped or not, is answered one cycle after the strobe.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Read data stands only with the acknowledge and is zero otherwise.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_word;
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // retrain pulse
    // Upstream ports never pulse, since the request already folds in the direction.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            retrain_o <= 1'b0;
        end else begin
            retrain_o <= retrain_req;
        end
    end

    // sync counts
    // Registered so the training logic never sees a decode glitch.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_o <= '0;
            ctrl_o.rx_l0s_ok <= 1'b1;
            ctrl_o.fts_count <= `LCC_NORM_FTS;
            ctrl_o.ts1_count <= `LCC_NORM_TS1;
        end else begin
            ctrl_o.l0s_en       <= aspm_ctl_reg[0];
            ctrl_o.l1_en        <= aspm_ctl_reg[1];
            ctrl_o.rx_l0s_ok    <= 1'b1;
            ctrl_o.link_disable <= disable_reg;
            ctrl_o.common_clk   <= cclk_reg;
            ctrl_o.ext_sync     <= xsync_reg;
            if (xsync_reg) begin
                ctrl_o.fts_count <= `LCC_XSYNC_FTS;
                ctrl_o.ts1_count <= `LCC_XSYNC_TS1;
            end else begin
                ctrl_o.fts_count <= `LCC_NORM_FTS;
                ctrl_o.ts1_count <= `LCC_NORM_TS1;
            end
        end
    end

endmodule

// ==== testbench/lcc_link_regs_props.sv ====
// Checker for the link register bank, watching its ports only.
// Assumes the bind in the bench top hands on the port parameters.
module lcc_link_regs_props #(
    parameter int unsigned PORT_INDEX  = 0,
    parameter bit          SDE_SUPPORT = 1'b0,
    parameter bit          HOTPLUG_CAP = 1'b0
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire lcc_pkg::lcc_ctrl_s ctrl_o,
    input wire logic              retrain_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam bit DN = PORT_INDEX != 0;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_take_ctl;
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'hf0 && wb_sel_i[0];
    endsequence
    sequence s_rd(a);
        wb_ack_o && !wb_we_i && wb_adr_i == a;
    endsequence
    property p_speed;
        s_rd(8'hec) |-> wb_dat_o[3:0] == 4'h1;
    endproperty
    property p_cap_fix;
        s_rd(8'hec) |-> wb_dat_o[23:18] == {3'h0, DN && HOTPLUG_CAP, DN && SDE_SUPPORT, 1'b0};
    endproperty
    property p_ctl_zero;
        s_rd(8'hf0) |-> wb_dat_o[15:8] == 8'h00 && {wb_dat_o[5], wb_dat_o[3:2]} == 3'h0;
    endproperty
    property p_retrain;
        s_take_ctl ##0 wb_dat_i[5] |=> retrain_o == DN;
    endproperty
    property p_retrain_cause;
        retrain_o |-> $past(wb_dat_i[5]) && $past(wb_we_i && wb_adr_i == 8'hf0);
    endproperty
    property p_aspm;
        s_take_ctl |-> ##2 ctrl_o.l0s_en == $past(wb_dat_i[0], 2)
            && ctrl_o.l1_en == $past(wb_dat_i[1], 2);
    endproperty
    property p_ctl_bits;
        s_take_ctl |-> ##2 ctrl_o.link_disable == (DN && $past(wb_dat_i[4], 2))
            && ctrl_o.common_clk == $past(wb_dat_i[6], 2)
            && ctrl_o.ext_sync == $past(wb_dat_i[7], 2);
    endproperty
    property p_rx_l0s;
        ctrl_o.rx_l0s_ok;
    endproperty
    property p_counts;
        ctrl_o.fts_count == (ctrl_o.ext_sync ? 13'h1000 : 13'h0080)
            && ctrl_o.ts1_count == (ctrl_o.ext_sync ? 13'h0400 : 13'h0010);
    endproperty
    a_speed: assert property (p_speed) else $error("speed field wrong");
    a_cap_fix: assert property (p_cap_fix) else $error("fixed cap bits wrong");
    a_ctl_zero: assert property (p_ctl_zero) else $error("control zero bits set");
    a_retrain: assert property (p_retrain) else $error("retrain pulse wrong");
    a_retrain_cause: assert property (p_retrain_cause) else $error("stray retrain");
    a_aspm: assert property (p_aspm) else $error("aspm enables wrong");
    a_ctl_bits: assert property (p_ctl_bits) else $error("control outputs wrong");
    a_rx_l0s: assert property (p_rx_l0s) else $error("receiver l0s blocked");
    a_counts: assert property (p_counts) else $error("sync counts wrong");
endmodule

// ==== testbench/lcc_link_partner.sv ====
// Far-side model: link training logic answering retrain requests.
// Assumes retrain_i is a one-cycle pulse; hold_i sets how slowly it trains.
module lcc_link_partner (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       retrain_i,
    input  wire logic [4:0] hold_i,
    output logic            active_o,
    output logic            done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt_reg;
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            cnt_reg  <= 5'h00;
            active_o <= 1'b0;
        end else if (retrain_i) begin
            cnt_reg  <= hold_i;
            active_o <= 1'b1;
        end else if (active_o) begin
            cnt_reg <= cnt_reg - 5'h01;
            if (cnt_reg == 5'h00) begin
                active_o <= 1'b0;
                done_o   <= 1'b1;
            end
        end
    end
endmodule

// ==== testbench/lcc_link_regs_tb_top.sv ====
// Bench top for the register bank as a hot-plug downstream port.
// Assumes package, design, checker and partner are compiled first.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s exp %h got %h", nm, e, g); end end
module lcc_link_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pv = 0;
    logic                  ack, ret, ta, td, dl = 0;
    logic [7:0]            adr = 8'h00;
    logic [3:0]            sel = 4'h0;
    logic [31:0]           wdat = 0, rdat, d, e_m;
    logic [5:0]            strap = 6'h04, nw = 6'h01;
    lcc_pkg::lcc_preload_s pre = '0, pre_v;
    lcc_pkg::lcc_ctrl_s    ctrl;
    logic [31:0]           q[$];
    int                    error_cnt = 0, n_tests = 0, seed = 32'hb28c140d;
    lcc_link_regs #(.PORT_INDEX(1), .SDE_SUPPORT(1'b0), .HOTPLUG_CAP(1'b1)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .width_strap_i(strap), .preload_valid_i(pv), .preload_i(pre), .train_active_i(ta),
        .train_done_i(td), .neg_width_i(nw), .dl_active_i(dl), .ctrl_o(ctrl), .retrain_o(ret));
    lcc_link_partner u_far (.clk_i(clk_i), .rst_i(rst_i), .retrain_i(ret), .hold_i(5'h0c),
        .active_o(ta), .done_o(td));
    initial forever #25 clk_i = ~clk_i;
    function automatic logic [31:0] cap_exp(input logic [7:0] p, input logic [2:0] l1,
        input logic [2:0] l0s, input logic [1:0] asp, input logic [5:0] w);
        return {p, 3'h0, 1'b1, 2'h0, l1, l0s, asp, w, 4'h1};
    endfunction
    function automatic logic [31:0] ctl_exp(input logic [31:0] v, input logic trn);
        return {2'h0, dl, 1'b0, trn, 1'b0, nw, 4'h1, 8'h00, v[7:6], 1'b0, v[4], 2'h0, v[1:0]};
    endfunction
    task automatic conclude;
        if (q.size() != 0) error_cnt++;
        $display("mismatches %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v,
        input logic [3:0] s);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        sel <= s;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 16);
        if (ack !== 1'b1) begin
            error_cnt++;
            conclude();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'($random(seed)), 4'hf);
    endtask
    always @(posedge clk_i) if (ack === 1'b1 && we === 1'b0) begin
        e_m = (q.size() > 0) ? q.pop_front() : 32'hdeadbeef;
        `CHK("rdata", e_m, rdat)
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'hec, cap_exp(8'h01, 3'h0, 3'h3, 2'h1, strap));
        rd(8'hf0, ctl_exp(32'h0, 1'b0));
        bus(1'b1, 8'hec, 32'hffffffff, 4'hf);
        rd(8'hec, cap_exp(8'h01, 3'h0, 3'h3, 2'h1, strap));
        bus(1'b1, 8'h40, 32'($random(seed)), 4'hf);
        rd(8'h40, 32'h0);
        for (int k = 0; k < 4; k++) begin
            {dl, nw} <= 7'($random(seed));
            d = 32'($random(seed)) & 32'hffffffdf;
            d[1:0] = k[1:0];
            bus(1'b1, 8'hf0, d, 4'h1);
            `CHK("l0s_en", d[0], ctrl.l0s_en)
            `CHK("l1_en", d[1], ctrl.l1_en)
            `CHK("rx_l0s", 1'b1, ctrl.rx_l0s_ok)
            `CHK("fts", d[7] ? 13'h1000 : 13'h0080, ctrl.fts_count)
            `CHK("ts1", d[7] ? 13'h0400 : 13'h0010, ctrl.ts1_count)
            `CHK("disable", d[4], ctrl.link_disable)
            `CHK("cclk", d[6], ctrl.common_clk)
            rd(8'hf0, ctl_exp(d, 1'b0));
            bus(1'b1, 8'hf0, ~d, 4'he);
            rd(8'hf0, ctl_exp(d, 1'b0));
        end
        bus(1'b1, 8'hf0, 32'h20, 4'h1);
        rd(8'hf0, ctl_exp(32'h0, 1'b1));
        repeat (20) @(posedge clk_i);
        rd(8'hf0, ctl_exp(32'h0, 1'b0));
        pre_v = 22'($random(seed));
        pre <= pre_v;
        pv <= 1'b1;
        @(posedge clk_i);
        pv <= 1'b0;
        rd(8'hec, cap_exp(pre_v.port_num, pre_v.l1_lat, pre_v.l0s_lat, pre_v.aspm_sup,
            pre_v.max_width));
        repeat (2) @(posedge clk_i);
        conclude();
    end
endmodule
bind lcc_link_regs lcc_link_regs_props #(.PORT_INDEX(PORT_INDEX), .SDE_SUPPORT(SDE_SUPPORT),
    .HOTPLUG_CAP(HOTPLUG_CAP)) u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctrl_o(ctrl_o),
    .retrain_o(retrain_o));
